// ===== inc/adcs_map.vh
`ifndef ADCS_MAP_VH
`define ADCS_MAP_VH
// register byte offsets
`define ADCS_OFF_ENABLE   12'h000
`define ADCS_OFF_RAWINT   12'h004
`define ADCS_OFF_MASK     12'h008
`define ADCS_OFF_ISC      12'h00C
`define ADCS_OFF_OVF      12'h010
`define ADCS_OFF_TRIGSEL  12'h014
`define ADCS_OFF_UNF      12'h018
`define ADCS_OFF_PRIO     12'h020
`define ADCS_OFF_SWINIT   12'h028
`define ADCS_OFF_AVG      12'h030
// per-sequencer block: base + 0x20*n
`define ADCS_OFF_SEQBASE  12'h040
`define ADCS_SEQ_STRIDE   12'h020
`define ADCS_SEQ_MUX      12'h000
`define ADCS_SEQ_CTL      12'h004
`define ADCS_SEQ_FIFO     12'h008
`define ADCS_SEQ_FSTAT    12'h00C
// reset values
`define ADCS_RST_PRIO     32'h00003210
// control nibble fields
`define ADCS_CTL_DIFF     0
`define ADCS_CTL_LAST     1
`define ADCS_CTL_IE       2
`define ADCS_CTL_TEMP     3
// trigger source codes
`define ADCS_TRIG_SW      4'h0
`define ADCS_TRIG_ALWAYS  4'hF
// fifo status field positions
`define ADCS_FS_TAIL      0
`define ADCS_FS_HEAD      4
`define ADCS_FS_EMPTY     8
`define ADCS_FS_FULL      12
// averaging exponent limit (2^6 = 64 samples)
`define ADCS_AVG_MAX      3'h6
// bus responses
`define ADCS_RESP_OKAY    2'h0
`define ADCS_RESP_SLVERR  2'h2
`endif

// ===== hw/adcs_top.v
// Operation
// [RULE1] 10-bit results, eight inputs plus temperature
// [RULE2] four sequencers, step lists, own FIFOs
// [RULE3] depths 8,4,4,1 steps and entries
// [RULE4] FIFO word 32 bits, result low
// [RULE5] step has input and control nibbles
// [RULE6] control flags: temp, irq, last, diff
// [RULE7] sequencer runs only while enabled; code checks enable only at grant, a started sequence runs to its end
// [RULE8] raw interrupt after each flagged step
// [RULE9] sequence ends at first last-step flag
// [RULE10] circular FIFO, read pops oldest entry
// [RULE11] status shows head, tail, full, empty
// [RULE12] overflow and underflow flags recorded
// [RULE13] runs on converter clock near 16.667MHz
// [RULE14] raw always shown, output masked
// [RULE15] write one clears interrupt, zero ignored
// [RULE16] pending triggers served highest priority first
// [RULE17] software keeps priorities distinct
// [RULE18] trigger source chosen per sequencer field
// [RULE19] software initiate triggers sw-source sequencer
// [RULE20] software avoids high-priority always trigger
// [RULE21] averaging up to 64, one entry
// [RULE22] averaging off at reset, shared stage
// [RULE23] priority resets to 3210
// [RULE24] single-ended codes 000 to 3FF
// [RULE25] full FIFO drops new result, flags
// [RULE26] empty read harmless, flags underflow
`timescale 1ns/1ps
`include "adcs_map.vh"
module adcs_top (
  // clock, reset, enable (converter clock domain)
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        clk_en_i,
  // axi4-lite write
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // trigger events from peripherals, one per source code
  input  wire [15:0] trig_events_i,
  // converter core
  output reg         conv_start_o,
  output reg  [3:0]  conv_input_o,
  output reg         conv_diff_o,
  output reg         conv_temp_o,
  input  wire        conv_done_i,
  input  wire [9:0]  conv_data_i,
  // combined interrupt
  output reg         irq_o
);

////////////////////////////////////////////////////////////////////////////////
// reset synchroniser and event input synchroniser

reg        rst_meta_ff;
reg        rst_sync_ff;
reg [15:0] trig_meta_ff;
reg [15:0] trig_sync_ff;
wire       rst_n = rst_sync_ff;

always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    rst_meta_ff <= 1'b0;
    rst_sync_ff <= 1'b0;
  end else begin
    rst_meta_ff <= 1'b1;
    rst_sync_ff <= rst_meta_ff;
  end
end

// peripheral events come from other logic, so they are synchronised first
always @(posedge clk_i or negedge rst_n) begin
  if (!rst_n) begin
    trig_meta_ff <= 16'h0000;
    trig_sync_ff <= 16'h0000;
  end else if (clk_en_i) begin
    trig_meta_ff <= trig_events_i;
    trig_sync_ff <= trig_meta_ff;
  end
end

////////////////////////////////////////////////////////////////////////////////
// helpers

function [3:0] seq_depth;
  input [1:0] s;
  begin
    case (s)
      2'd0:    seq_depth = 4'd8;
      2'd3:    seq_depth = 4'd1;
      default: seq_depth = 4'd4;
    endcase
  end
endfunction

// one flat 32-word result store, 8 slots per sequencer
function [4:0] slot;
  input [1:0] s;
  input [2:0] p;
  begin
    slot = {s, p};
  end
endfunction

function [2:0] ptr_inc;
  input [1:0] s;
  input [2:0] p;
  begin
    ptr_inc = ({1'b0, p} + 4'd1 >= seq_depth(s)) ? 3'd0 : p + 3'd1;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg [3:0]  enable_ff;
reg [3:0]  rawint_ff;
reg [3:0]  mask_ff;
reg [3:0]  ovf_ff;
reg [3:0]  unf_ff;
reg [15:0] trigsel_ff;
reg [15:0] prio_ff;
reg [2:0]  avg_ff;
reg [31:0] mux_ff [0:3];
reg [31:0] ctl_ff [0:3];
reg [9:0]  fifo_mem [0:31];
reg [2:0]  head_ff [0:3];
reg [2:0]  tail_ff [0:3];
reg [3:0]  count_ff [0:3];
reg [3:0]  pend_ff;

// sequencing state
localparam ST_IDLE = 2'd0;
localparam ST_CONV = 2'd1;
localparam ST_WAIT = 2'd2;
reg [1:0]  state_ff;
reg [1:0]  cur_ff;
reg [2:0]  step_ff;
reg [6:0]  avg_cnt_ff;
reg [15:0] acc_ff;

// axi latches
reg        aw_ok_ff;
reg        w_ok_ff;
reg [11:0] awaddr_ff;
reg [31:0] wdata_ff;
reg [3:0]  wstrb_ff;

////////////////////////////////////////////////////////////////////////////////
// decode

function [2:0] seq_reg;   // {valid, which word}
  input [11:0] a;
  reg   [11:0] r;
  begin
    r = a - `ADCS_OFF_SEQBASE;
    seq_reg = (a >= `ADCS_OFF_SEQBASE && a < `ADCS_OFF_SEQBASE + 4 * `ADCS_SEQ_STRIDE && r[4] == 1'b0)
              ? {1'b1, r[3:2]} : 3'b000;
  end
endfunction

wire [11:0] wrel = awaddr_ff - `ADCS_OFF_SEQBASE;
wire [11:0] rrel = s_axi_araddr - `ADCS_OFF_SEQBASE;
wire [2:0]  wsr  = seq_reg(awaddr_ff);
wire [2:0]  rsr  = seq_reg(s_axi_araddr);
wire [1:0]  wsq  = wrel[6:5];
wire [1:0]  rsq  = rrel[6:5];
wire        do_wr = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
wire        do_rd = s_axi_arvalid && s_axi_arready;
wire        rd_pop = do_rd && rsr[2] && rsr[1:0] == 2'd2;

function [31:0] merge;
  input [31:0] o;
  input [31:0] d;
  input [3:0]  st;
  integer      i;
  begin
    merge = o;
    for (i = 0; i < 4; i = i + 1)
      if (st[i])
        merge[i*8 +: 8] = d[i*8 +: 8];
  end
endfunction

wire [31:0] wd = merge(32'h00000000, wdata_ff, wstrb_ff);
wire        wr_top = do_wr && !wsr[2];
wire [31:0] enable_wr = merge({28'h0000000, enable_ff}, wdata_ff, wstrb_ff);
wire [31:0] trig_wr   = merge({16'h0000, trigsel_ff}, wdata_ff, wstrb_ff);
wire [31:0] prio_wr   = merge({16'h0000, prio_ff}, wdata_ff, wstrb_ff);
localparam [31:0] PRIO_RST = `ADCS_RST_PRIO;

////////////////////////////////////////////////////////////////////////////////
// trigger arbitration

reg [3:0] trig_hit;
reg       grant_v;
reg [1:0] grant;
reg [1:0] best_p;
integer   k;
always @* begin
  trig_hit = 4'h0;
  grant_v  = 1'b0;
  grant    = 2'd0;
  best_p   = 2'd3;
  for (k = 0; k < 4; k = k + 1) begin
    // see [RULE18]
    if (trigsel_ff[k*4 +: 4] == `ADCS_TRIG_ALWAYS)
      trig_hit[k] = 1'b1;
    else if (trigsel_ff[k*4 +: 4] != `ADCS_TRIG_SW)
      trig_hit[k] = trig_sync_ff[trigsel_ff[k*4 +: 4]];
  end
  for (k = 0; k < 4; k = k + 1) begin
    // see [RULE7] [RULE16]
    if (enable_ff[k] && (pend_ff[k] || trig_hit[k]) && (!grant_v || prio_ff[k*4 +: 2] < best_p)) begin
      grant_v = 1'b1;
      grant   = k[1:0];
      best_p  = prio_ff[k*4 +: 2];
    end
  end
end

wire [3:0] step_ctl = ctl_ff[cur_ff][step_ff*4 +: 4];              // see [RULE5] [RULE6]
wire [3:0] step_mux = mux_ff[cur_ff][step_ff*4 +: 4];
wire [6:0] avg_n    = 7'd1 << avg_ff;                              // see [RULE21] [RULE22]
wire [15:0] acc_sum = acc_ff + {6'h00, conv_data_i};
wire [9:0] avg_res  = acc_sum[avg_ff +: 10];
wire       result_v = state_ff == ST_WAIT && conv_done_i && (avg_cnt_ff + 7'd1 == avg_n);
wire [3:0] step_lim = seq_depth(cur_ff);
wire       seq_end  = step_ctl[`ADCS_CTL_LAST] || ({1'b0, step_ff} + 4'd1 >= step_lim); // see [RULE9] [RULE3]
wire       fifo_full = count_ff[cur_ff] == step_lim;

// a pop on one fifo and a push on another can fall in the same cycle
reg [3:0] pop_hit;
reg [3:0] push_hit;
always @* begin
  pop_hit  = 4'h0;
  push_hit = 4'h0;
  if (rd_pop && count_ff[rsq] != 4'd0)
    pop_hit[rsq] = 1'b1;
  if (result_v && !fifo_full)
    push_hit[cur_ff] = 1'b1;
end

////////////////////////////////////////////////////////////////////////////////
// main state

integer j;
always @(posedge clk_i or negedge rst_n) begin
  if (!rst_n) begin
    enable_ff     <= 4'h0;
    rawint_ff     <= 4'h0;
    mask_ff       <= 4'h0;
    ovf_ff        <= 4'h0;
    unf_ff        <= 4'h0;
    trigsel_ff    <= 16'h0000;
    prio_ff       <= PRIO_RST[15:0];                               // see [RULE23]
    avg_ff        <= 3'h0;
    pend_ff       <= 4'h0;
    state_ff      <= ST_IDLE;
    cur_ff        <= 2'd0;
    step_ff       <= 3'd0;
    avg_cnt_ff    <= 7'd0;
    acc_ff        <= 16'h0000;
    aw_ok_ff      <= 1'b0;
    w_ok_ff       <= 1'b0;
    awaddr_ff     <= 12'h000;
    wdata_ff      <= 32'h00000000;
    wstrb_ff      <= 4'h0;
    s_axi_awready <= 1'b0;
    s_axi_wready  <= 1'b0;
    s_axi_bvalid  <= 1'b0;
    s_axi_bresp   <= `ADCS_RESP_OKAY;
    s_axi_arready <= 1'b0;
    s_axi_rvalid  <= 1'b0;
    s_axi_rresp   <= `ADCS_RESP_OKAY;
    s_axi_rdata   <= 32'h00000000;
    conv_start_o  <= 1'b0;
    conv_input_o  <= 4'h0;
    conv_diff_o   <= 1'b0;
    conv_temp_o   <= 1'b0;
    irq_o         <= 1'b0;
    for (j = 0; j < 4; j = j + 1) begin
      mux_ff[j]   <= 32'h00000000;
      ctl_ff[j]   <= 32'h00000000;
      head_ff[j]  <= 3'd0;
      tail_ff[j]  <= 3'd0;
      count_ff[j] <= 4'd0;
    end
  end else if (clk_en_i) begin
    // write channel: address and data taken in either order
    s_axi_awready <= !aw_ok_ff && !s_axi_awready;
    s_axi_wready  <= !w_ok_ff && !s_axi_wready;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_ff  <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_ok_ff  <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    if (do_wr) begin
      aw_ok_ff     <= 1'b0;
      w_ok_ff      <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= `ADCS_RESP_OKAY;
      if (wsr[2]) begin
        if (wsr[1:0] == 2'd0)
          mux_ff[wsq] <= merge(mux_ff[wsq], wdata_ff, wstrb_ff);
        else if (wsr[1:0] == 2'd1)
          ctl_ff[wsq] <= merge(ctl_ff[wsq], wdata_ff, wstrb_ff);
      end else begin
        case (awaddr_ff)
          `ADCS_OFF_ENABLE:  enable_ff  <= enable_wr[3:0];
          `ADCS_OFF_MASK:    mask_ff    <= wstrb_ff[0] ? wdata_ff[3:0] : mask_ff;
          `ADCS_OFF_TRIGSEL: trigsel_ff <= trig_wr[15:0];
          `ADCS_OFF_PRIO:    prio_ff    <= prio_wr[15:0];
          `ADCS_OFF_AVG:     avg_ff     <= wstrb_ff[0] ? ((wdata_ff[2:0] > `ADCS_AVG_MAX) ? `ADCS_AVG_MAX
                                                          : wdata_ff[2:0]) : avg_ff;
          `ADCS_OFF_ISC, `ADCS_OFF_OVF, `ADCS_OFF_UNF, `ADCS_OFF_SWINIT: ;
          default:           s_axi_bresp <= `ADCS_RESP_SLVERR;
        endcase
      end
    end
    if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;

    // read channel
    s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
    if (do_rd) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `ADCS_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      if (rsr[2]) begin
        case (rsr[1:0])
          2'd0: s_axi_rdata <= mux_ff[rsq];
          2'd1: s_axi_rdata <= ctl_ff[rsq];
          2'd2: s_axi_rdata <= {22'h000000, fifo_mem[slot(rsq, tail_ff[rsq])]}; // see [RULE4] [RULE10] [RULE26]
          default: begin
            s_axi_rdata[`ADCS_FS_TAIL +: 3] <= tail_ff[rsq];                   // see [RULE11]
            s_axi_rdata[`ADCS_FS_HEAD +: 3] <= head_ff[rsq];
            s_axi_rdata[`ADCS_FS_EMPTY]     <= count_ff[rsq] == 4'd0;
            s_axi_rdata[`ADCS_FS_FULL]      <= count_ff[rsq] == seq_depth(rsq);
          end
        endcase
      end else begin
        case (s_axi_araddr)
          `ADCS_OFF_ENABLE:  s_axi_rdata[3:0]  <= enable_ff;
          `ADCS_OFF_RAWINT:  s_axi_rdata[3:0]  <= rawint_ff;               // see [RULE14]
          `ADCS_OFF_MASK:    s_axi_rdata[3:0]  <= mask_ff;
          `ADCS_OFF_ISC:     s_axi_rdata[3:0]  <= rawint_ff & mask_ff;
          `ADCS_OFF_OVF:     s_axi_rdata[3:0]  <= ovf_ff;
          `ADCS_OFF_UNF:     s_axi_rdata[3:0]  <= unf_ff;
          `ADCS_OFF_TRIGSEL: s_axi_rdata[15:0] <= trigsel_ff;
          `ADCS_OFF_PRIO:    s_axi_rdata[15:0] <= prio_ff;
          `ADCS_OFF_AVG:     s_axi_rdata[2:0]  <= avg_ff;
          `ADCS_OFF_SWINIT: ;
          default:           s_axi_rresp <= `ADCS_RESP_SLVERR;
        endcase
      end
    end
    if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;

    // pending software triggers; a grant clears, a fresh initiate wins
    for (j = 0; j < 4; j = j + 1) begin
      if (state_ff == ST_IDLE && grant_v && grant == j[1:0])
        pend_ff[j] <= 1'b0;
      if (wr_top && awaddr_ff == `ADCS_OFF_SWINIT && wd[j] && trigsel_ff[j*4 +: 4] == `ADCS_TRIG_SW)
        pend_ff[j] <= 1'b1;                                        // see [RULE19]
    end

    // sticky flags: hardware set wins over a write-one clear
    for (j = 0; j < 4; j = j + 1) begin
      if (wr_top && awaddr_ff == `ADCS_OFF_ISC && wd[j])
        rawint_ff[j] <= 1'b0;                                      // see [RULE15]
      if (wr_top && awaddr_ff == `ADCS_OFF_OVF && wd[j])
        ovf_ff[j] <= 1'b0;
      if (wr_top && awaddr_ff == `ADCS_OFF_UNF && wd[j])
        unf_ff[j] <= 1'b0;
      if (rd_pop && rsq == j[1:0] && count_ff[j] == 4'd0)
        unf_ff[j] <= 1'b1;                                         // see [RULE12] [RULE26]
    end

    // fifo pop by software; push from sequencer below
    if (pop_hit[rsq])
      tail_ff[rsq] <= ptr_inc(rsq, tail_ff[rsq]);
    for (j = 0; j < 4; j = j + 1) begin
      if (pop_hit[j] && !push_hit[j])
        count_ff[j] <= count_ff[j] - 4'd1;
      else if (push_hit[j] && !pop_hit[j])
        count_ff[j] <= count_ff[j] + 4'd1;
    end

    // sequencer engine; the converter is shared, one step at a time
    conv_start_o <= 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (grant_v) begin
          cur_ff     <= grant;
          step_ff    <= 3'd0;
          avg_cnt_ff <= 7'd0;
          acc_ff     <= 16'h0000;
          state_ff   <= ST_CONV;
        end
      end
      ST_CONV: begin
        conv_start_o <= 1'b1;
        conv_input_o <= step_mux;                                  // see [RULE1]
        conv_diff_o  <= step_ctl[`ADCS_CTL_DIFF];
        conv_temp_o  <= step_ctl[`ADCS_CTL_TEMP];
        state_ff     <= ST_WAIT;
      end
      ST_WAIT: begin
        if (conv_done_i) begin
          if (!result_v) begin
            acc_ff     <= acc_sum;
            avg_cnt_ff <= avg_cnt_ff + 7'd1;
            state_ff   <= ST_CONV;
          end else begin
            acc_ff     <= 16'h0000;
            avg_cnt_ff <= 7'd0;
            if (fifo_full) begin
              ovf_ff[cur_ff] <= 1'b1;                               // see [RULE12] [RULE25]
            end else begin
              fifo_mem[slot(cur_ff, head_ff[cur_ff])] <= avg_res;    // see [RULE2] [RULE24]
              head_ff[cur_ff] <= ptr_inc(cur_ff, head_ff[cur_ff]);
            end
            if (step_ctl[`ADCS_CTL_IE])
              rawint_ff[cur_ff] <= 1'b1;                           // see [RULE8]
            step_ff  <= step_ff + 3'd1;
            state_ff <= seq_end ? ST_IDLE : ST_CONV;               // see [RULE9]
          end
        end
      end
      default: state_ff <= ST_IDLE;
    endcase

    irq_o <= |(rawint_ff & mask_ff);                               // see [RULE14]
  end
end

// note: whole design is clocked by the converter clock     see [RULE13]
endmodule

// ===== dv/adcs_conv_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module adcs_conv_model (
  // clock and reset
  input  logic       clk_i,
  input  logic       rst_n_i,
  // latency choice: low answers next cycle, high after six
  input  logic       slow_i,
  // conversion request
  input  logic       start_i,
  input  logic [3:0] sel_i,
  input  logic       diff_i,
  input  logic       temp_i,
  // conversion answer
  output logic       done_o,
  output logic [9:0] data_o
);
  logic       busy;
  logic [2:0] cnt;
  logic [9:0] res;

  // result encodes the selects, so the bench can tell which step produced it
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy   <= 1'b0;
      cnt    <= 3'h0;
      res    <= 10'h000;
      done_o <= 1'b0;
      data_o <= 10'h000;
    end else begin
      done_o <= 1'b0;
      // data bus shows garbage outside the done cycle
      data_o <= ~res;
      if (start_i) begin
        busy <= 1'b1;
        cnt  <= slow_i ? 3'h6 : 3'h1;
        res  <= {temp_i, diff_i, sel_i, 4'hA};
      end else if (busy) begin
        cnt <= cnt - 3'h1;
        if (cnt == 3'h1) begin
          busy   <= 1'b0;
          done_o <= 1'b1;
          data_o <= res;
        end
      end
    end
  end
endmodule

// ===== dv/adcs_properties.sv
`timescale 1ns/1ps
`include "adcs_map.vh"
////////////////////////////////////////////////////////////////////////////////
module adcs_properties (
  // clock and reset
  input logic        clk_i,
  input logic        rst_n_i,
  // bus handshakes
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [11:0] s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  // converter side and interrupt
  input logic        conv_start_o,
  input logic [3:0]  conv_input_o,
  input logic        conv_diff_o,
  input logic        conv_temp_o,
  input logic        conv_done_i,
  input logic        irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  start_gap_a: assert property (conv_start_o |=> !conv_start_o [*2])
    else $error("conversion starts too close");
  done_gap_a: assert property (conv_done_i |=> !conv_start_o)
    else $error("start right after done");
  sel_hold_a: assert property (conv_start_o ##1 !conv_done_i |-> $stable(conv_input_o) &&
    $stable(conv_diff_o) && $stable(conv_temp_o)) else $error("selects moved mid conversion");
  aw_once_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  ar_once_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("second read address taken");
  fifo_word_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 12'h048 |=> s_axi_rdata[31:10] == 22'h0) else $error("fifo word upper bits set");

  cover property (conv_done_i);
  cover property (irq_o);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind adcs_top adcs_properties u_props (.clk_i, .rst_n_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .conv_start_o, .conv_input_o, .conv_diff_o, .conv_temp_o, .conv_done_i, .irq_o);

// ===== dv/tb_adc_sample_sequencer_control.sv
`timescale 1ns/1ps
`include "adcs_map.vh"
////////////////////////////////////////////////////////////////////////////////
module tb_adc_sample_sequencer_control;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        slow = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [15:0] trig_ev = 16'h0000;
  logic [1:0]  bresp_seen;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        conv_start_o, conv_diff_o, conv_temp_o, conv_done_i, irq_o;
  logic [3:0]  conv_input_o;
  logic [9:0]  conv_data_i;
  logic [3:0]  sel_log [64];
  int          checks = 0;
  int          miscompares = 0;
  int          starts = 0;
  int          dones = 0;

  always #2.5 clk_i = ~clk_i;

  adcs_top dut (.clk_i, .rst_n_i, .clk_en_i(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .trig_events_i(trig_ev), .conv_start_o, .conv_input_o,
    .conv_diff_o, .conv_temp_o, .conv_done_i, .conv_data_i, .irq_o);

  adcs_conv_model u_conv (.clk_i, .rst_n_i, .slow_i(slow), .start_i(conv_start_o), .sel_i(conv_input_o),
    .diff_i(conv_diff_o), .temp_i(conv_temp_o), .done_o(conv_done_i), .data_o(conv_data_i));

  // log the input select of every conversion to check step order and arbitration
  always @(posedge clk_i) begin
    if (conv_start_o === 1'b1) begin
      sel_log[starts] <= conv_input_o;
      starts <= starts + 1;
    end
    if (conv_done_i === 1'b1) dones <= dones + 1;
  end

  function automatic [11:0] sq(input int n, input [11:0] f);
    return 12'(`ADCS_OFF_SEQBASE + `ADCS_SEQ_STRIDE * n + f);
  endfunction

  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input [31:0] seen, input [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 500) begin
      miscompares++;
      $display("Error at %0t: wait ran out", $time);
      finish_test();
    end
  endtask

  task automatic wr(input [11:0] a, input [31:0] d);
    int n;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 500);
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask

  task automatic rd(input [11:0] a, output [31:0] d, output [1:0] r);
    int n;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 500);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask

  task automatic rchk(input [11:0] a, input [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
  endtask

  // results land in the fifo one cycle after done, hence the short settle
  task automatic wait_conv(input int t);
    int n;
    n = 0;
    while (dones < t && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    tmo(n);
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    logic [31:0] d;
    logic [31:0] st;
    logic [1:0]  r;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rchk(`ADCS_OFF_PRIO, `ADCS_RST_PRIO);
    rchk(`ADCS_OFF_AVG, 32'h0);
    rchk(`ADCS_OFF_ENABLE, 32'h0);
    rd(12'hFFC, d, r);
    chk({30'h0, r}, {30'h0, `ADCS_RESP_SLVERR});
    // raw status is read-only, a write is refused
    wr(`ADCS_OFF_RAWINT, 32'hF);
    chk({30'h0, bresp_seen}, {30'h0, `ADCS_RESP_SLVERR});
    rchk(`ADCS_OFF_RAWINT, 32'h0);
    // sequencer zero: diff step, flagged step, last step with temp
    wr(sq(0, `ADCS_SEQ_MUX), 32'h87654321);
    wr(sq(0, `ADCS_SEQ_CTL), 32'h00004A41);
    wr(`ADCS_OFF_MASK, 32'h1);
    wr(`ADCS_OFF_ENABLE, 32'h1);
    chk({30'h0, bresp_seen}, {30'h0, `ADCS_RESP_OKAY});
    wr(`ADCS_OFF_SWINIT, 32'h1);
    wait_conv(3);
    chk(starts, 3);
    for (int i = 0; i < 3; i++) chk(sel_log[i], i + 1);
    chk({31'h0, irq_o}, 32'h1);
    rchk(`ADCS_OFF_RAWINT, 32'h1);
    rchk(sq(0, `ADCS_SEQ_FIFO), 32'h11A);
    rchk(sq(0, `ADCS_SEQ_FIFO), 32'h02A);
    rchk(sq(0, `ADCS_SEQ_FIFO), 32'h23A);
    rd(sq(0, `ADCS_SEQ_FSTAT), st, r);
    chk({27'h0, st[12], st[8], st[6:4] ^ st[2:0]}, 32'h8);
    rd(sq(0, `ADCS_SEQ_FIFO), d, r);
    rchk(sq(0, `ADCS_SEQ_FSTAT), st);
    rchk(`ADCS_OFF_UNF, 32'h1);
    wr(`ADCS_OFF_UNF, 32'h1);
    rchk(`ADCS_OFF_UNF, 32'h0);
    wr(`ADCS_OFF_ISC, 32'h0);
    rchk(`ADCS_OFF_RAWINT, 32'h1);
    wr(`ADCS_OFF_ISC, 32'h1);
    rchk(`ADCS_OFF_RAWINT, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    // sequencer three, masked off, run twice into its one-entry fifo
    wr(`ADCS_OFF_MASK, 32'h0);
    wr(sq(3, `ADCS_SEQ_MUX), 32'h5);
    wr(sq(3, `ADCS_SEQ_CTL), 32'h6);
    wr(`ADCS_OFF_ENABLE, 32'h9);
    wr(`ADCS_OFF_SWINIT, 32'h8);
    wait_conv(4);
    wr(`ADCS_OFF_ENABLE, 32'h1);
    wr(sq(3, `ADCS_SEQ_MUX), 32'h6);
    wr(`ADCS_OFF_ENABLE, 32'h9);
    wr(`ADCS_OFF_SWINIT, 32'h8);
    wait_conv(5);
    chk({31'h0, irq_o}, 32'h0);
    rchk(`ADCS_OFF_RAWINT, 32'h8);
    rchk(`ADCS_OFF_ISC, 32'h0);
    rchk(`ADCS_OFF_OVF, 32'h8);
    rchk(sq(3, `ADCS_SEQ_FIFO), 32'h05A);
    wr(`ADCS_OFF_OVF, 32'h8);
    rchk(`ADCS_OFF_OVF, 32'h0);
    // simultaneous software triggers, sequencer two given top priority
    wr(`ADCS_OFF_PRIO, 32'h00003021);
    wr(sq(1, `ADCS_SEQ_MUX), 32'h4);
    wr(sq(1, `ADCS_SEQ_CTL), 32'h2);
    wr(sq(2, `ADCS_SEQ_MUX), 32'h7);
    wr(sq(2, `ADCS_SEQ_CTL), 32'h2);
    wr(`ADCS_OFF_ENABLE, 32'h6);
    wr(`ADCS_OFF_SWINIT, 32'h6);
    wait_conv(7);
    chk(sel_log[5], 32'h7);
    chk(sel_log[6], 32'h4);
    // four-sample averaging with a slow converter
    slow <= 1'b1;
    wr(`ADCS_OFF_AVG, 32'h2);
    wr(`ADCS_OFF_ENABLE, 32'h8);
    wr(`ADCS_OFF_SWINIT, 32'h8);
    wait_conv(11);
    chk(starts, 11);
    rchk(sq(3, `ADCS_SEQ_FIFO), 32'h06A);
    rd(sq(3, `ADCS_SEQ_FSTAT), st, r);
    chk({31'h0, st[8]}, 32'h1);
    // peripheral event on sequencer one; always trigger kept at the lowest priority
    slow <= 1'b0;
    wr(`ADCS_OFF_AVG, 32'h0);
    wr(`ADCS_OFF_ENABLE, 32'h2);
    wr(`ADCS_OFF_TRIGSEL, 32'h0000F050);
    wr(`ADCS_OFF_SWINIT, 32'h2);
    repeat (20) @(posedge clk_i);
    chk(starts, 11);
    trig_ev <= 16'h0020;
    @(posedge clk_i);
    trig_ev <= 16'h0000;
    wait_conv(12);
    chk(starts, 12);
    chk(sel_log[11], 32'h4);
    wr(`ADCS_OFF_ENABLE, 32'hA);
    wait_conv(14);
    chk(sel_log[13], 32'h6);
    wr(`ADCS_OFF_ENABLE, 32'h0);
    rchk(`ADCS_OFF_OVF, 32'h8);
    finish_test();
  end
endmodule
